// ---- hw/uvlo_gain_regs.sv ----
// input start/stop threshold and current-sense gain configuration registers
// Notes on behaviour
// - register 35h holds the input level above which conversion may start
// - in-range start writes snap to 0.25, 0.5 or 1 V steps up to 16 V
// - out-of-range threshold write keeps old value, flags invalid data, raises alert
// - start exponent fixed at minus two, 0.25 V lsb, not writable
// - start mantissa defaults to 17, accepts 17 through 64
// - register 36h holds the input level below which conversion stops
// - stop writes snap to 0.25 V, 0.5 V, then 1 V steps
// - stop exponent minus two, mantissa defaults 16, accepts 16 through 63
// - power-up defaults are fixed constants; stored user settings load only on nvm_load
// - register 38h holds current-sense gain in 15.26 micro-ohm steps
// - gain exponent fixed minus sixteen, mantissa default 32, range 16 to 508
// - gain is paged: 00 channel one, 01 channel two, 11 both
// - page 0 always writable; page 1 only as master, else mirrors page 0
// - page 1 write while slave is refused, flags invalid command, raises alert
// - exponent bits of a write rescale the value to the fixed lsb and are not stored
// - store-all copies every storable setting out as new defaults
`timescale 1ns/1ps
`include "uvlo_gain_params.svh"

module uvlo_gain_regs (
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  input  uvlo_gain_pkg::cmd_req_t        req,
  input  wire logic                      ch2_master,
  input  wire logic                      clear_faults,
  input  wire logic                      store_all,
  input  wire logic                      nvm_load,
  input  uvlo_gain_pkg::cfg_image_t      nvm_image_in,
  input  wire logic [15:0]               vin_level,
  output logic                           ack,
  output logic                           nack,
  output logic [15:0]                    rd_data,
  output uvlo_gain_pkg::fault_flags_t    flags,
  output logic                           alert_active,
  output logic                           nvm_store,
  output uvlo_gain_pkg::cfg_image_t      nvm_image_out,
  output uvlo_gain_pkg::cfg_image_t      cfg_out,
  output logic                           vin_start_ok,
  output logic                           vin_stop_hit
);
  import uvlo_gain_pkg::*;

  cfg_image_t   image;
  cfg_image_t   next_image;
  fault_flags_t next_flags;

  function automatic logic [15:0] make_word(input logic [4:0] e, input logic [10:0] m);
    return {e, m};
  endfunction : make_word

  // nearest start step; a tie goes to the higher step
  function automatic logic [10:0] snap_start(input logic [10:0] q);
    if (q <= `START_FINE_TOP) return q;
    else if (q <= `START_MID_TOP) return (q + 11'h001) & 11'h7FE;
    else return (q + 11'h002) & 11'h7FC;
  endfunction : snap_start

  // nearest stop step: quarters, then odd quarters, then 4n-1 quarters
  function automatic logic [10:0] snap_stop(input logic [10:0] q);
    if (q <= `STOP_FINE_TOP) return q;
    else if (q <= `STOP_MID_TOP) return q | 11'h001;
    else return ((q + 11'h003) & 11'h7FC) - 11'h001;
  endfunction : snap_stop

  // range test on the 0.25 V value, before step snapping
  function automatic logic in_range(input logic signed [15:0] v, input logic ov,
                                    input logic [10:0] lo, input logic [10:0] hi);
    return !ov && (16'(v) >= {5'h00, lo}) && (16'(v) <= {5'h00, hi});
  endfunction : in_range

  // value conversion
  logic signed [15:0] vin_val;
  logic               vin_ovf;
  logic signed [15:0] gain_val;
  logic               gain_ovf;

  linear_snap #(.TGT_EXP(`VIN_EXP_INT), .OW(16)) u_vin_snap (
    .word  (req.data),
    .value (vin_val),
    .ovf   (vin_ovf)
  );

  linear_snap #(.TGT_EXP(`GAIN_EXP_INT), .OW(16)) u_gain_snap (
    .word  (req.data),
    .value (gain_val),
    .ovf   (gain_ovf)
  );

  // command decode
  wire logic       hit_start  = (req.code == `CMD_VIN_START);
  wire logic       hit_stop   = (req.code == `CMD_VIN_STOP);
  wire logic       hit_gain   = (req.code == `CMD_IOUT_GAIN);
  wire logic       hit_any    = hit_start || hit_stop || hit_gain;
  wire logic [1:0] page_sel   = {req.page[`PAGE_BIT_HI], req.page[`PAGE_BIT_LO]};
  wire logic       page_ch1   = (page_sel == `PAGE_CH1) || (page_sel == `PAGE_BOTH);
  wire logic       page_ch2   = (page_sel == `PAGE_CH2) || (page_sel == `PAGE_BOTH);
  wire logic       page_bad   = (page_sel == `PAGE_BAD);
  wire logic       slave_hit  = page_ch2 && !ch2_master;

  // range checks and snapping
  wire logic [10:0] start_snap = snap_start(vin_val[10:0]);
  wire logic [10:0] stop_snap  = snap_stop(vin_val[10:0]);
  wire logic        start_ok   = in_range(vin_val, vin_ovf, `START_MIN, `START_MAX)
                                 && (start_snap > image.stop_mant);
  wire logic        stop_ok    = in_range(vin_val, vin_ovf, `STOP_MIN, `STOP_MAX)
                                 && (stop_snap < image.start_mant);
  wire logic        gain_ok    = in_range(gain_val, gain_ovf, `GAIN_MIN, `GAIN_MAX);

  // write outcome
  wire logic wr_hit      = req.wr && hit_any;
  wire logic gain_refuse = req.wr && hit_gain && (slave_hit || page_bad);
  wire logic bad_data    = req.wr && ((hit_start && !start_ok) || (hit_stop && !stop_ok)
                                      || (hit_gain && !gain_refuse && !gain_ok));
  wire logic wr_start    = req.wr && hit_start && start_ok;
  wire logic wr_stop     = req.wr && hit_stop && stop_ok;
  wire logic wr_gain     = req.wr && hit_gain && !gain_refuse && gain_ok;
  wire logic wr_gain1    = wr_gain && page_ch1;
  wire logic wr_gain2    = wr_gain && page_ch2;

  // next register image; a load of stored settings takes priority
  always_comb begin
    next_image = image;
    if (nvm_load) begin
      next_image = nvm_image_in;
    end else begin
      if (wr_start) next_image.start_mant = start_snap;
      if (wr_stop)  next_image.stop_mant  = stop_snap;
      if (wr_gain1) next_image.gain1_mant = gain_val[10:0];
      if (wr_gain2) next_image.gain2_mant = gain_val[10:0];
    end
  end

  // sticky faults; a new event beats a clear in the same cycle
  assign next_flags.cml = (bad_data || gain_refuse) || (flags.cml && !clear_faults);
  assign next_flags.ivd = bad_data || (flags.ivd && !clear_faults);
  assign next_flags.invalid_command_fault = gain_refuse || (flags.invalid_command_fault && !clear_faults);

  // read mux; exponents always read back fixed
  wire logic [10:0] gain2_eff = ch2_master ? image.gain2_mant : image.gain1_mant;
  wire logic [15:0] rd_mux    = hit_start ? make_word(`VIN_EXP_FIELD, image.start_mant) :
                                hit_stop  ? make_word(`VIN_EXP_FIELD, image.stop_mant) :
                                (page_sel == `PAGE_CH2) ? make_word(`GAIN_EXP_FIELD, gain2_eff) :
                                make_word(`GAIN_EXP_FIELD, image.gain1_mant);
  wire logic        rd_hit    = req.rd && !req.wr && hit_any;
  wire logic        next_ack  = (wr_hit && !gain_refuse) || rd_hit; // unmapped codes stay silent

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      image <= '{`START_DEF, `STOP_DEF, `GAIN_DEF, `GAIN_DEF};
      flags <= '0;
    end else begin
      image <= next_image;
      flags <= next_flags;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack          <= 1'b0;
      nack         <= 1'b0;
      alert_active <= 1'b0;
    end else begin
      ack          <= next_ack;
      nack         <= gain_refuse;
      alert_active <= next_flags.cml;
    end
  end

  // read word holds until the next read
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 16'h0000;
    end else if (rd_hit) begin
      rd_data <= rd_mux;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      nvm_store     <= 1'b0;
      nvm_image_out <= '0;
    end else begin
      nvm_store <= store_all;
      if (store_all) nvm_image_out <= image;
    end
  end

  // settings seen by the power stage; a slave channel two follows channel one
  wire cfg_image_t next_cfg = '{image.start_mant, image.stop_mant, image.gain1_mant, gain2_eff};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_out <= '{`START_DEF, `STOP_DEF, `GAIN_DEF, `GAIN_DEF};
    end else begin
      cfg_out <= next_cfg;
    end
  end

  // strict compares against the current thresholds
  wire logic next_start_ok = vin_level > {5'h00, image.start_mant};
  wire logic next_stop_hit = vin_level < {5'h00, image.stop_mant};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      vin_start_ok <= 1'b0;
      vin_stop_hit <= 1'b0;
    end else begin
      vin_start_ok <= next_start_ok;
      vin_stop_hit <= next_stop_hit;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_start_range: assert property (image.start_mant >= `START_MIN && image.start_mant <= `START_MAX)
    else $error("start threshold out of range");
  a_stop_range: assert property (image.stop_mant >= `STOP_MIN && image.stop_mant <= `STOP_MAX)
    else $error("stop threshold out of range");
  a_gain_range: assert property (image.gain1_mant >= `GAIN_MIN && image.gain1_mant <= `GAIN_MAX)
    else $error("gain out of range");
  a_start_step: assert property ((image.start_mant <= `START_FINE_TOP || !image.start_mant[0])
      && (image.start_mant <= `START_MID_TOP || image.start_mant[1:0] == 2'h0))
    else $error("start threshold off step");
  a_stop_step: assert property (image.stop_mant <= `STOP_FINE_TOP
      || (image.stop_mant <= `STOP_MID_TOP ? image.stop_mant[0] : image.stop_mant[1:0] == 2'h3))
    else $error("stop threshold off step");
  a_bad_keeps: assert property (req.wr && hit_start && !start_ok && !nvm_load
      |=> $stable(image.start_mant) && flags.ivd && flags.cml && alert_active)
    else $error("invalid start write not handled");
  a_slave_nack: assert property (req.wr && hit_gain && page_ch2 && !ch2_master && !nvm_load
      |=> nack && !ack && flags.invalid_command_fault && $stable(image.gain1_mant) && $stable(image.gain2_mant))
    else $error("slave page write not refused");
  a_exp_fixed: assert property (req.rd && !req.wr && hit_start
      |=> ack && rd_data[`WORD_EXP_HI:`WORD_EXP_LO] == `VIN_EXP_FIELD)
    else $error("start exponent not fixed");
  a_gain_exp: assert property (req.rd && !req.wr && hit_gain
      |=> rd_data[`WORD_EXP_HI:`WORD_EXP_LO] == `GAIN_EXP_FIELD)
    else $error("gain exponent not fixed");
  a_store_copy: assert property (store_all |=> nvm_store && nvm_image_out == $past(image))
    else $error("store image mismatch");
  a_slave_mirror: assert property (!ch2_master |=> cfg_out.gain2_mant == $past(image.gain1_mant))
    else $error("slave gain not mirrored");
  a_load_image: assert property (nvm_load |=> image == $past(nvm_image_in))
    else $error("stored settings not loaded");
  a_order_kept: assert property (image.stop_mant < image.start_mant || $past(nvm_load))
    else $error("stop not below start");

  // fault, paging and output checks
  a_gain2_range: assert property (image.gain2_mant >= `GAIN_MIN && image.gain2_mant <= `GAIN_MAX)
    else $error("channel two gain out of range");
  a_stop_keeps: assert property (req.wr && hit_stop && !stop_ok && !nvm_load
      |=> $stable(image.stop_mant) && flags.ivd && flags.cml && alert_active)
    else $error("invalid stop write not handled");
  a_gain_keeps: assert property (req.wr && hit_gain && !gain_refuse && !gain_ok && !nvm_load
      |=> $stable(image.gain1_mant) && $stable(image.gain2_mant) && flags.ivd)
    else $error("invalid gain write not handled");
  a_set_wins: assert property (bad_data |=> flags.ivd && flags.cml && alert_active)
    else $error("invalid data flag lost");
  a_fault_clear: assert property (clear_faults && !bad_data && !gain_refuse
      |=> !flags.cml && !alert_active)
    else $error("faults not cleared");
  a_refuse_alert: assert property (gain_refuse |=> flags.invalid_command_fault && flags.cml && alert_active)
    else $error("refused write raised no alert");
  a_one_answer: assert property (!(ack && nack))
    else $error("ack and nack together");
  a_quiet_unmapped: assert property ((req.wr || req.rd) && !hit_any |=> !ack && !nack)
    else $error("unmapped command answered");
  a_ch1_only: assert property (wr_gain && page_sel == `PAGE_CH1 && !nvm_load
      |=> $stable(image.gain2_mant))
    else $error("channel one write reached channel two");
  a_ch2_write: assert property (wr_gain && page_sel == `PAGE_CH2 && !nvm_load
      |=> image.gain2_mant == $past(gain_val[10:0]) && $stable(image.gain1_mant))
    else $error("channel two write not taken");
  a_both_write: assert property (wr_gain && page_sel == `PAGE_BOTH && !nvm_load
      |=> image.gain1_mant == image.gain2_mant)
    else $error("both-channel write split");
  a_slave_read: assert property (req.rd && !req.wr && hit_gain && page_sel == `PAGE_CH2 && !ch2_master
      |=> rd_data[`WORD_MANT_HI:`WORD_MANT_LO] == $past(image.gain1_mant))
    else $error("slave read not mirrored");
  a_start_cmp: assert property (vin_level > {5'h00, image.start_mant} |=> vin_start_ok)
    else $error("start level not reported");
  a_stop_cmp: assert property (vin_level < {5'h00, image.stop_mant} |=> vin_stop_hit)
    else $error("stop level not reported");
  a_cfg_follow: assert property (1'b1 |=> cfg_out.start_mant == $past(image.start_mant)
      && cfg_out.stop_mant == $past(image.stop_mant))
    else $error("settings output lags");
  a_store_pulse: assert property (!store_all |=> !nvm_store && $stable(nvm_image_out))
    else $error("store strobe without command");

  c_start_write: cover property (wr_start ##1 ack);
  c_slave_refuse: cover property (gain_refuse ##1 nack);
  c_bad_data: cover property (bad_data ##1 alert_active);
  c_store: cover property (store_all ##1 nvm_store);
  c_set_wins: cover property (bad_data && clear_faults);

endmodule : uvlo_gain_regs

// ---- hw/uvlo_gain_params.svh ----
// constants for the input threshold and current gain register bank
`ifndef UVLO_GAIN_PARAMS_SVH
`define UVLO_GAIN_PARAMS_SVH

`define CMD_VIN_START     8'h35
`define CMD_VIN_STOP      8'h36
`define CMD_IOUT_GAIN     8'h38

`define WORD_EXP_HI       15
`define WORD_EXP_LO       11
`define WORD_MANT_HI      10
`define WORD_MANT_LO      0

`define PAGE_BIT_HI       7
`define PAGE_BIT_LO       0
`define PAGE_CH1          2'h0
`define PAGE_CH2          2'h1
`define PAGE_BAD          2'h2
`define PAGE_BOTH         2'h3

`define VIN_EXP_FIELD     5'h1E
`define GAIN_EXP_FIELD    5'h10
`define VIN_EXP_INT       (-2)
`define GAIN_EXP_INT      (-16)

`define START_DEF         11'h011
`define START_MIN         11'h011
`define START_MAX         11'h040
`define START_FINE_TOP    11'h028
`define START_MID_TOP     11'h034

`define STOP_DEF          11'h010
`define STOP_MIN          11'h010
`define STOP_MAX          11'h03F
`define STOP_FINE_TOP     11'h025
`define STOP_MID_TOP      11'h033

`define GAIN_DEF          11'h020
`define GAIN_MIN          11'h010
`define GAIN_MAX          11'h1FC

`endif

// ---- hw/uvlo_gain_pkg.sv ----
// types shared by the input threshold and current gain register bank
package uvlo_gain_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  code;
    logic [7:0]  page;
    logic [15:0] data;
  } cmd_req_t;

  typedef struct packed {
    logic [10:0] start_mant;
    logic [10:0] stop_mant;
    logic [10:0] gain1_mant;
    logic [10:0] gain2_mant;
  } cfg_image_t;

  typedef struct packed {
    logic cml;
    logic ivd;
    logic invalid_command_fault;
  } fault_flags_t;

endpackage : uvlo_gain_pkg

// ---- hw/linear_snap.sv ----
// converts a linear-format word to a rounded value in a fixed target lsb
`timescale 1ns/1ps
`include "uvlo_gain_params.svh"

module linear_snap #(
  parameter int TGT_EXP = `VIN_EXP_INT,
  parameter int OW      = 16
) (
  input  wire logic [15:0]          word,
  output logic      signed [OW-1:0] value,
  output logic                      ovf
);

  // value = mantissa * 2^exponent, rescaled to 2^TGT_EXP
  wire logic signed [6:0]  shift_amt = 7'(signed'(word[`WORD_EXP_HI:`WORD_EXP_LO])) - 7'(TGT_EXP);
  wire logic        [5:0]  mag       = shift_amt[6] ? 6'(-shift_amt) : 6'(shift_amt);
  wire logic signed [47:0] wide      = 48'(signed'(word[`WORD_MANT_HI:`WORD_MANT_LO]));
  wire logic signed [47:0] up        = wide <<< mag;
  wire logic signed [47:0] half      = (mag == 6'h00) ? 48'sh0 : (48'sh1 <<< (mag - 6'h01));
  wire logic signed [47:0] down      = (wide + half) >>> mag;
  wire logic signed [47:0] full      = shift_amt[6] ? down : up;
  wire logic        [47-OW+1:0] top  = full[47:OW-1];

  assign value = full[OW-1:0];
  assign ovf   = !((&top) || !(|top));

endmodule : linear_snap

// ---- tb/pmbus_host.sv ----
// host-side command source for the register bank
`timescale 1ns/1ps
module pmbus_host (
  input  wire logic               mclk,
  output uvlo_gain_pkg::cmd_req_t req,
  input  wire logic               ack,
  input  wire logic               nack,
  input  wire logic [15:0]        rd_data
);
  import uvlo_gain_pkg::*;
  initial req = '0;
  // one command pulse; answer sampled the cycle after it is taken
  task cmd(input logic w, input logic [7:0] c, input logic [7:0] p, input logic [15:0] d,
           output logic a, output logic n, output logic [15:0] r);
    @(posedge mclk);
    req <= '{wr: w, rd: !w, code: c, page: p, data: d};
    @(posedge mclk);
    // released lines show the inverse, not the last value
    req <= '{wr: 1'b0, rd: 1'b0, code: ~c, page: ~p, data: ~d};
    #1;
    a = ack;
    n = nack;
    r = rd_data;
  endtask : cmd
endmodule : pmbus_host

// ---- tb/tb_input_uvlo_and_current_gain_config.sv ----
// self-checking bench for the threshold and gain register bank
`timescale 1ns/1ps
`include "uvlo_gain_params.svh"
module tb_input_uvlo_and_current_gain_config;
  import uvlo_gain_pkg::*;
  logic         mclk, rst_b, ch2_master, clear_faults, store_all, nvm_load;
  logic         ack, nack, alert_active, nvm_store, vin_start_ok, vin_stop_hit;
  logic [15:0]  vin_level, rd_data;
  cmd_req_t     req;
  cfg_image_t   nvm_image_in, nvm_image_out, cfg_out;
  fault_flags_t flags;
  int           error_cnt, checks;

  uvlo_gain_regs i_dut (.mclk(mclk), .rst_b(rst_b), .req(req), .ch2_master(ch2_master),
    .clear_faults(clear_faults), .store_all(store_all), .nvm_load(nvm_load),
    .nvm_image_in(nvm_image_in), .vin_level(vin_level), .ack(ack), .nack(nack),
    .rd_data(rd_data), .flags(flags), .alert_active(alert_active), .nvm_store(nvm_store),
    .nvm_image_out(nvm_image_out), .cfg_out(cfg_out), .vin_start_ok(vin_start_ok),
    .vin_stop_hit(vin_stop_hit));
  pmbus_host i_host (.mclk(mclk), .req(req), .ack(ack), .nack(nack), .rd_data(rd_data));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task chk(input string nm, input logic [43:0] e, input logic [43:0] g);
    checks++;
    if (e !== g) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  task wr(input logic [7:0] c, input logic [7:0] p, input logic [15:0] d, input logic ea);
    logic a, n;
    logic [15:0] r;
    i_host.cmd(1'b1, c, p, d, a, n, r);
    chk("ack", ea, a);
    chk("nack", !ea, n);
  endtask : wr

  task rd(input logic [7:0] c, input logic [7:0] p, input logic [15:0] e);
    logic a, n;
    logic [15:0] r;
    i_host.cmd(1'b0, c, p, 16'h0000, a, n, r);
    chk("read ack", 1'b1, a);
    chk("rd_data", e, r);
  endtask : rd

  // one-cycle strobe: 0 clear, 1 store, 2 load
  task pulse(input logic [1:0] k);
    @(posedge mclk);
    clear_faults <= (k == 2'h0);
    store_all    <= (k == 2'h1);
    nvm_load     <= (k == 2'h2);
    @(posedge mclk);
    clear_faults <= 1'b0;
    store_all    <= 1'b0;
    nvm_load     <= 1'b0;
    #1;
  endtask : pulse

  task fault(input logic [2:0] e);
    chk("flags", e, flags);
    chk("alert", e[2], alert_active);
    pulse(2'h0);
    chk("flags cleared", 3'h0, flags);
    chk("alert cleared", 1'b0, alert_active);
  endtask : fault

  task t_odd;
    logic a, n;
    logic [15:0] r;
    i_host.cmd(1'b1, 8'h37, 8'h00, 16'hF020, a, n, r);
    chk("unmapped answer", 2'h0, {a, n});
    fork
      i_host.cmd(1'b1, `CMD_VIN_START, 8'h00, 16'hF041, a, n, r);
      begin
        @(posedge mclk);
        clear_faults <= 1'b1;
        @(posedge mclk);
        clear_faults <= 1'b0;
      end
    join
    chk("clash ack", 1'b1, a);
    fault(3'b110);
  endtask : t_odd

  task t_reset;
    chk("cfg defaults", {11'h011, 11'h010, 11'h020, 11'h020}, cfg_out);
    rd(`CMD_VIN_START, 8'h00, 16'hF011);
    rd(`CMD_VIN_STOP, 8'h00, 16'hF010);
    rd(`CMD_IOUT_GAIN, 8'h00, 16'h8020);
  endtask : t_reset

  task t_start;
    wr(`CMD_VIN_START, 8'h00, 16'hF014, 1'b1);
    rd(`CMD_VIN_START, 8'h00, 16'hF014);
    wr(`CMD_VIN_START, 8'h00, 16'hF80A, 1'b1);
    rd(`CMD_VIN_START, 8'h00, 16'hF014);
    wr(`CMD_VIN_START, 8'h00, 16'hF029, 1'b1);
    rd(`CMD_VIN_START, 8'h00, 16'hF02A);
    wr(`CMD_VIN_START, 8'h00, 16'hF035, 1'b1);
    rd(`CMD_VIN_START, 8'h00, 16'hF034);
    wr(`CMD_VIN_START, 8'h00, 16'hF041, 1'b1);
    fault(3'b110);
    rd(`CMD_VIN_START, 8'h00, 16'hF034);
  endtask : t_start

  task t_stop;
    // one stop write here lands above start and must be refused
    wr(`CMD_VIN_STOP, 8'h00, 16'hF026, 1'b1);
    rd(`CMD_VIN_STOP, 8'h00, 16'hF027);
    wr(`CMD_VIN_STOP, 8'h00, 16'hF040, 1'b1);
    fault(3'b110);
    wr(`CMD_VIN_STOP, 8'h00, 16'hF035, 1'b1);
    fault(3'b110);
    rd(`CMD_VIN_STOP, 8'h00, 16'hF027);
  endtask : t_stop

  task t_gain;
    wr(`CMD_IOUT_GAIN, 8'h00, 16'h8064, 1'b1);
    @(posedge mclk);
    #1;
    chk("slave gain", {11'h064, 11'h064}, cfg_out[21:0]);
    wr(`CMD_IOUT_GAIN, 8'h01, 16'h80C8, 1'b0);
    fault(3'b101);
    wr(`CMD_IOUT_GAIN, 8'h81, 16'h80C8, 1'b0);
    fault(3'b101);
    rd(`CMD_IOUT_GAIN, 8'h01, 16'h8064);
    @(posedge mclk);
    ch2_master <= 1'b1;
    wr(`CMD_IOUT_GAIN, 8'h01, 16'h80C8, 1'b1);
    wr(`CMD_IOUT_GAIN, 8'h80, 16'h8032, 1'b0);
    fault(3'b101);
    rd(`CMD_IOUT_GAIN, 8'h01, 16'h80C8);
    rd(`CMD_IOUT_GAIN, 8'h00, 16'h8064);
    wr(`CMD_IOUT_GAIN, 8'h81, 16'h812C, 1'b1);
    rd(`CMD_IOUT_GAIN, 8'h01, 16'h812C);
    rd(`CMD_IOUT_GAIN, 8'h00, 16'h812C);
    wr(`CMD_IOUT_GAIN, 8'h00, 16'h81FD, 1'b1);
    fault(3'b110);
  endtask : t_gain

  task t_nvm;
    pulse(2'h1);
    chk("nvm_store", 1'b1, nvm_store);
    chk("stored image", {11'h034, 11'h027, 11'h12C, 11'h12C}, nvm_image_out);
    nvm_image_in <= {11'h014, 11'h010, 11'h032, 11'h03C};
    pulse(2'h2);
    vin_level <= 16'h0015;
    repeat (2) @(posedge mclk);
    #1;
    chk("loaded cfg", {11'h014, 11'h010, 11'h032, 11'h03C}, cfg_out);
    chk("start ok", 1'b1, vin_start_ok);
    chk("stop hit", 1'b0, vin_stop_hit);
    vin_level <= 16'h000F;
    repeat (3) @(posedge mclk);
    #1;
    chk("stop hit low", 1'b1, vin_stop_hit);
    chk("start ok low", 1'b0, vin_start_ok);
  endtask : t_nvm

  initial begin
    #200000;
    error_cnt++;
    finish_test;
  end

  initial begin
    rst_b = 1'b0;
    ch2_master = 1'b0;
    clear_faults = 1'b0;
    store_all = 1'b0;
    nvm_load = 1'b0;
    nvm_image_in = '0;
    vin_level = 16'h0000;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset;
    t_start;
    t_odd;
    t_stop;
    t_gain;
    t_nvm;
    finish_test;
  end
endmodule : tb_input_uvlo_and_current_gain_config
